// ===== hw/dsp_datapath_cfg.svh
`ifndef DSP_DATAPATH_CFG_SVH
`define DSP_DATAPATH_CFG_SVH

// datapath widths
`define ACC_W 32
`define WORD_W 16
`define AUX_N 8
`define PTR_W 3
`define SHIFT_W 3
`define RPT_W 8
`define HIGH_SHIFT 16

// reset values
`define CARRY_RESET 1'b1
`define SXM_RESET 1'b0
`define PTR_RESET 3'h0

// status-1 word layout used by the load-status operation
`define ST1_CARRY_BIT 9
`define ST1_SXM_BIT 10
`define ST1_PTR_LSB 13

// axi4-lite register map
`define AXI_ADDR_W 12
`define OFF_CTRL 12'h000
`define OFF_STATUS 12'h004
`define OFF_ACC 12'h008
`define OFF_AUX_CUR 12'h00C
`define OFF_AUX_INDEX 12'h010

// control and status field positions
`define CTRL_SXM_BIT 0
`define STAT_CARRY_BIT 0
`define STAT_SXM_BIT 1
`define STAT_BUSY_BIT 2
`define STAT_PTR_LSB 4

`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

// ===== hw/dsp_datapath_pkg.sv
package dsp_datapath_pkg;
`include "dsp_datapath_cfg.svh"

  typedef logic [`WORD_W-1:0] word_t;
  typedef logic [`ACC_W-1:0] acc_t;
  typedef logic [`PTR_W-1:0] ptr_t;

  typedef enum logic [4:0] {
    OP_NOP,
    OP_LOAD_ACC,
    OP_ADD,
    OP_ADD_HIGH,
    OP_SUB,
    OP_SUB_HIGH,
    ADD_WITH_CARRY_OP,
    SUBTRACT_WITH_BORROW_OP,
    OP_AND,
    OP_OR,
    OP_XOR,
    ACC_SHIFT_LEFT_OP,
    ACC_SHIFT_RIGHT_OP,
    ACC_ROTATE_LEFT_OP,
    ACC_ROTATE_RIGHT_OP,
    SET_FLAG_OP,
    CLEAR_FLAG_OP,
    LOAD_STATUS_OP,
    OP_STORE_LO,
    OP_STORE_HI,
    OP_LOAD_AR,
    OP_LOAD_PTR,
    OP_STORE_AR
  } op_code_t;

  typedef enum logic [2:0] {SRC_MEM, SRC_IMM, SRC_PROD, SRC_ACC, SRC_AUX} src_t;

  typedef enum logic [2:0] {ADDR_NONE, ADDR_INC, ADDR_DEC, ADDR_ADD_INDEX, ADDR_SUB_INDEX} addr_mode_t;

  typedef enum logic [1:0] {COND_CARRY, COND_NO_CARRY, COND_ALWAYS} cond_t;

  typedef struct packed {
    op_code_t code;
    src_t src;
    word_t operand;
    ptr_t ar_sel;
    addr_mode_t addr_mode;
    logic [`SHIFT_W-1:0] store_shift;
    logic [`RPT_W-1:0] rpt_count;
  } op_t;

endpackage : dsp_datapath_pkg

// ===== hw/aux_reg_file.sv
`timescale 1ns/1ps
`include "dsp_datapath_cfg.svh"
module aux_reg_file (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire dsp_datapath_pkg::ptr_t waddr,
  input wire dsp_datapath_pkg::word_t wdata,
  input wire dsp_datapath_pkg::ptr_t raddr,
  output dsp_datapath_pkg::word_t rdata,
  output dsp_datapath_pkg::word_t index_rdata
);
  import dsp_datapath_pkg::*;

  word_t mem_q [`AUX_N];
  word_t rdata_q;
  word_t index_q;

  for (genvar i = 0; i < `AUX_N; i++) begin : g_entry
    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        mem_q[i] <= 16'h0000;
      end else if (we && (waddr == ptr_t'(i))) begin
        mem_q[i] <= wdata;
      end
    end
  end

  // write-first so the read registers always mirror the addressed entries
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rdata_q <= 16'h0000;
      index_q <= 16'h0000;
    end else begin
      rdata_q <= (we && (waddr == raddr)) ? wdata : mem_q[raddr];
      index_q <= (we && (waddr == ptr_t'(0))) ? wdata : mem_q[0];
    end
  end

  assign rdata = rdata_q;
  assign index_rdata = index_q;

endmodule : aux_reg_file

// ===== hw/dsp_carry_acc_aux_datapath.sv
// Functional notes
// - arithmetic and single-bit shifts update carry; loads other than status load and logic don't
// - add/subtract with carry use old carry
// - high-half add only sets, subtract only clears
// - carry-set and carry-clear condition codes
// - set, clear and status load write carry
// - reset forces carry to one
// - 32-bit accumulator, stored as two halves
// - store path shifts left 0-7, accumulator unchanged
// - high store fills from low; low store zero-fills
// - single-bit shifts and rotates pass through carry
// - right shift keeps sign when sign-extend mode
// - left shift always inserts zero at bit 0
// - repeat reissues shift for multi-bit shifts
// - eight aux registers chosen by 3-bit pointer
// - aux and pointer loaded from many sources
// - address unit steps by one or index
`timescale 1ns/1ps
`include "dsp_datapath_cfg.svh"
module dsp_carry_acc_aux_datapath (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_valid,
  output logic op_ready,
  input wire dsp_datapath_pkg::op_t op,
  input wire dsp_datapath_pkg::word_t mem_rdata,
  input wire dsp_datapath_pkg::acc_t product_reg,
  input wire dsp_datapath_pkg::cond_t cond_sel,
  output logic cond_true,
  output dsp_datapath_pkg::word_t dmem_addr,
  output logic store_valid,
  output dsp_datapath_pkg::word_t store_data,
  output dsp_datapath_pkg::acc_t accumulator_reg,
  output logic carry,
  input wire logic [`AXI_ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [`AXI_ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready
);
  import dsp_datapath_pkg::*;

  localparam logic [`RPT_W-1:0] RPT_ONE = 8'h01;
  localparam word_t STEP_ONE = 16'h0001;

  acc_t acc_q, acc_d;
  logic carry_q, carry_d;
  logic sxm_q, sxm_d;
  ptr_t ptr_q, ptr_d;
  logic busy_q;
  logic busy_d;
  logic [`RPT_W-1:0] rpt_cnt_q, rpt_cnt_d;
  op_t op_q;
  op_t x;
  op_code_t code;
  logic store_valid_q, store_valid_d;
  word_t store_data_q, store_data_d;

  // repeat sequencer: the held operation is reissued until the count runs out
  wire accept = op_valid & ~busy_q;
  wire exec_valid = accept | busy_q;
  assign op_ready = ~busy_q;
  assign x = busy_q ? op_q : op;
  assign code = exec_valid ? x.code : OP_NOP;
  assign busy_d = accept ? (op.rpt_count != '0) : (busy_q & (rpt_cnt_q != RPT_ONE));
  assign rpt_cnt_d = accept ? op.rpt_count : (busy_q ? rpt_cnt_q - RPT_ONE : rpt_cnt_q);

  // operand selection
  word_t aux_cur, aux_index, src_word;
  acc_t ext_word, low_opnd, high_opnd, b_opnd, b_eff;
  assign src_word = (x.src == SRC_MEM) ? mem_rdata :
                    (x.src == SRC_IMM) ? x.operand :
                    (x.src == SRC_PROD) ? product_reg[15:0] :
                    (x.src == SRC_ACC) ? acc_q[15:0] : aux_cur;
  assign ext_word = sxm_q ? {{16{src_word[15]}}, src_word} : {16'h0000, src_word};
  assign low_opnd = (x.src == SRC_PROD) ? product_reg : ext_word;
  assign high_opnd = acc_t'({src_word, 16'h0000});

  wire high_op = (code == OP_ADD_HIGH) | (code == OP_SUB_HIGH);
  wire sub_op = (code == OP_SUB) | (code == OP_SUB_HIGH) | (code == SUBTRACT_WITH_BORROW_OP);
  wire chain_op = (code == ADD_WITH_CARRY_OP) | (code == SUBTRACT_WITH_BORROW_OP);
  assign b_opnd = high_op ? high_opnd : low_opnd;
  assign b_eff = sub_op ? ~b_opnd : b_opnd;
  wire cin = chain_op ? carry_q : ((code == OP_SUB) | (code == OP_SUB_HIGH));
  logic [32:0] sum;
  assign sum = {1'b0, acc_q} + {1'b0, b_eff} + {32'h0000_0000, cin};
  wire cout = sum[32];

  // store path shifter, accumulator itself untouched
  acc_t acc_shl;
  word_t lo_shl;
  assign acc_shl = acc_q << x.store_shift;
  assign lo_shl = acc_q[15:0] << x.store_shift;

  // auxiliary address unit
  word_t step, aux_mod;
  wire step_up = (x.addr_mode == ADDR_INC) | (x.addr_mode == ADDR_ADD_INDEX);
  wire load_ar = (code == OP_LOAD_AR);
  // index by one or index register
  assign step = ((x.addr_mode == ADDR_INC) | (x.addr_mode == ADDR_DEC)) ? STEP_ONE : aux_index;
  assign aux_mod = step_up ? aux_cur + step : aux_cur - step;
  wire modify = exec_valid & (x.addr_mode != ADDR_NONE) & ~load_ar;
  wire aux_we = load_ar | modify;
  wire ptr_t aux_waddr = load_ar ? x.ar_sel : ptr_q;
  wire word_t aux_wdata = load_ar ? src_word : aux_mod;

  // axi write side holding registers
  logic aw_have_q, w_have_q;
  logic [`AXI_ADDR_W-1:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic bvalid_q;
  logic [1:0] bresp_q;
  wire wr_go = aw_have_q & w_have_q & ~bvalid_q;
  wire wr_ctrl = wr_go & (aw_addr_q == `OFF_CTRL);
  wire ctrl_wr = wr_ctrl & w_strb_q[0];

  // next-state of the datapath
  always_comb begin
    acc_d = acc_q;
    carry_d = carry_q;
    sxm_d = ctrl_wr ? w_data_q[`CTRL_SXM_BIT] : sxm_q;
    ptr_d = ptr_q;
    store_valid_d = 1'b0;
    store_data_d = store_data_q;
    unique case (code)
      OP_LOAD_ACC: acc_d = low_opnd;
      OP_ADD, OP_SUB, ADD_WITH_CARRY_OP, SUBTRACT_WITH_BORROW_OP: begin
        acc_d = sum[31:0];
        carry_d = cout;
      end
      OP_ADD_HIGH: begin
        acc_d = sum[31:0];
        carry_d = carry_q | cout;
      end
      OP_SUB_HIGH: begin
        acc_d = sum[31:0];
        carry_d = carry_q & cout;
      end
      OP_AND: acc_d = acc_q & ext_word;
      OP_OR: acc_d = acc_q | ext_word;
      OP_XOR: acc_d = acc_q ^ ext_word;
      ACC_SHIFT_LEFT_OP: begin
        acc_d = {acc_q[30:0], 1'b0};
        carry_d = acc_q[31];
      end
      ACC_SHIFT_RIGHT_OP: begin
        acc_d = {sxm_q & acc_q[31], acc_q[31:1]};
        carry_d = acc_q[0];
      end
      ACC_ROTATE_LEFT_OP: begin
        acc_d = {acc_q[30:0], carry_q};
        carry_d = acc_q[31];
      end
      ACC_ROTATE_RIGHT_OP: begin
        acc_d = {carry_q, acc_q[31:1]};
        carry_d = acc_q[0];
      end
      SET_FLAG_OP: carry_d = 1'b1;
      CLEAR_FLAG_OP: carry_d = 1'b0;
      LOAD_STATUS_OP: begin
        carry_d = src_word[`ST1_CARRY_BIT];
        sxm_d = src_word[`ST1_SXM_BIT];
        ptr_d = src_word[`ST1_PTR_LSB +: `PTR_W];
      end
      OP_STORE_LO: begin
        store_valid_d = 1'b1;
        store_data_d = lo_shl;
      end
      OP_STORE_HI: begin
        store_valid_d = 1'b1;
        store_data_d = acc_shl[31:16];
      end
      OP_LOAD_PTR: ptr_d = src_word[`PTR_W-1:0];
      OP_STORE_AR: begin
        store_valid_d = 1'b1;
        store_data_d = aux_cur;
      end
      OP_NOP, OP_LOAD_AR: begin
      end
      default: begin
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      acc_q <= 32'h0000_0000;
      carry_q <= `CARRY_RESET;
      sxm_q <= `SXM_RESET;
      ptr_q <= `PTR_RESET;
    end else begin
      acc_q <= acc_d;
      carry_q <= carry_d;
      sxm_q <= sxm_d;
      ptr_q <= ptr_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      busy_q <= 1'b0;
      rpt_cnt_q <= 8'h00;
      op_q <= '0;
      store_valid_q <= 1'b0;
      store_data_q <= 16'h0000;
    end else begin
      busy_q <= busy_d;
      rpt_cnt_q <= rpt_cnt_d;
      if (accept) begin
        op_q <= op;
      end
      store_valid_q <= store_valid_d;
      store_data_q <= store_data_d;
    end
  end

  aux_reg_file u_aux (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(aux_we),
    .waddr(aux_waddr),
    .wdata(aux_wdata),
    .raddr(ptr_d),
    .rdata(aux_cur),
    .index_rdata(aux_index)
  );

  assign cond_true = (cond_sel == COND_ALWAYS) |
                     ((cond_sel == COND_CARRY) & carry_q) |
                     ((cond_sel == COND_NO_CARRY) & ~carry_q);
  assign dmem_addr = aux_cur;
  assign store_valid = store_valid_q;
  assign store_data = store_data_q;
  assign accumulator_reg = acc_q;
  assign carry = carry_q;

  // axi4-lite write channel
  assign awready = ~aw_have_q;
  assign wready = ~w_have_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      aw_addr_q <= 12'h000;
    end else if (awvalid && !aw_have_q) begin
      aw_have_q <= 1'b1;
      aw_addr_q <= awaddr;
    end else if (wr_go) begin
      aw_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_have_q <= 1'b0;
      w_data_q <= 32'h0000_0000;
      w_strb_q <= 4'h0;
    end else if (wvalid && !w_have_q) begin
      w_have_q <= 1'b1;
      w_data_q <= wdata;
      w_strb_q <= wstrb;
    end else if (wr_go) begin
      w_have_q <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q <= `RESP_OKAY;
    end else if (wr_go) begin
      bvalid_q <= 1'b1;
      bresp_q <= wr_ctrl ? `RESP_OKAY : `RESP_SLVERR;
    end else if (bready) begin
      bvalid_q <= 1'b0;
    end
  end

  // axi4-lite read channel
  logic [31:0] status_word, ctrl_word, rd_word;
  always_comb begin
    status_word = 32'h0000_0000;
    status_word[`STAT_CARRY_BIT] = carry_q;
    status_word[`STAT_SXM_BIT] = sxm_q;
    status_word[`STAT_BUSY_BIT] = busy_q;
    status_word[`STAT_PTR_LSB +: `PTR_W] = ptr_q;
    ctrl_word = 32'h0000_0000;
    ctrl_word[`CTRL_SXM_BIT] = sxm_q;
  end
  wire rd_hit = (araddr == `OFF_CTRL) | (araddr == `OFF_STATUS) | (araddr == `OFF_ACC) |
                (araddr == `OFF_AUX_CUR) | (araddr == `OFF_AUX_INDEX);
  assign rd_word = (araddr == `OFF_CTRL) ? ctrl_word :
                   (araddr == `OFF_STATUS) ? status_word :
                   (araddr == `OFF_ACC) ? acc_q :
                   (araddr == `OFF_AUX_CUR) ? {16'h0000, aux_cur} :
                   (araddr == `OFF_AUX_INDEX) ? {16'h0000, aux_index} : 32'h0000_0000;

  logic rvalid_q;
  logic [31:0] rdata_q;
  logic [1:0] rresp_q;
  assign arready = ~rvalid_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_q <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rresp_q <= `RESP_OKAY;
    end else if (arvalid && !rvalid_q) begin
      rvalid_q <= 1'b1;
      rdata_q <= rd_word;
      rresp_q <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rready) begin
      rvalid_q <= 1'b0;
    end
  end

endmodule : dsp_carry_acc_aux_datapath

// ===== verif/dsp_datapath_checker.sv
`timescale 1ns/1ps
module dsp_datapath_checker (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic op_valid,
  input wire logic op_ready,
  input wire dsp_datapath_pkg::op_t op,
  input wire dsp_datapath_pkg::cond_t cond_sel,
  input wire logic cond_true,
  input wire logic store_valid,
  input wire dsp_datapath_pkg::word_t store_data,
  input wire dsp_datapath_pkg::acc_t accumulator_reg,
  input wire logic carry
);
  import dsp_datapath_pkg::*;
  wire logic take = op_valid && op_ready;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  reset_carry_a: assert property ($rose(aresetn) |-> carry)
    else $error("carry not set after reset");
  cond_map_a: assert property (cond_true == (cond_sel == COND_CARRY ? carry :
    cond_sel == COND_NO_CARRY ? !carry : cond_sel == COND_ALWAYS)) else $error("condition output wrong");
  keep_carry_a: assert property (take && op.code inside {OP_LOAD_ACC, OP_AND, OP_OR, OP_XOR} |=>
    $stable(carry)) else $error("carry moved by load or logic op");
  set_clear_a: assert property (take && op.code inside {SET_FLAG_OP, CLEAR_FLAG_OP} |=>
    carry == ($past(op.code) == SET_FLAG_OP)) else $error("flag op did not write carry");
  high_half_a: assert property (take && (op.code == OP_ADD_HIGH && carry || op.code == OP_SUB_HIGH && !carry)
    |=> carry == $past(carry)) else $error("high-half op moved carry wrongly");
  shift_left_a: assert property (take && op.code == ACC_SHIFT_LEFT_OP && op.rpt_count == 8'h00 |=>
    {carry, accumulator_reg} == {$past(accumulator_reg), 1'b0}) else $error("left shift through carry wrong");
  store_hi_a: assert property (take && op.code == OP_STORE_HI |=> store_valid && $stable(accumulator_reg) &&
    store_data == 16'(($past(accumulator_reg) << $past(op.store_shift)) >> 16)) else $error("high store wrong");
  store_lo_a: assert property (take && op.code == OP_STORE_LO |=> store_valid &&
    store_data == 16'($past(accumulator_reg) << $past(op.store_shift))) else $error("low store wrong");
  repeat_busy_a: assert property (take && op.rpt_count == 8'h02 |=> !op_ready [*2] ##1 op_ready)
    else $error("repeat did not hold the op port");
endmodule : dsp_datapath_checker

bind dsp_carry_acc_aux_datapath dsp_datapath_checker u_checker (.aclk(aclk), .aresetn(aresetn),
  .op_valid(op_valid), .op_ready(op_ready), .op(op), .cond_sel(cond_sel), .cond_true(cond_true),
  .store_valid(store_valid), .store_data(store_data), .accumulator_reg(accumulator_reg), .carry(carry));

// ===== verif/dmem_model.sv
`timescale 1ns/1ps
module dmem_model (
  input wire dsp_datapath_pkg::word_t dmem_addr,
  output dsp_datapath_pkg::word_t mem_rdata
);
  import dsp_datapath_pkg::*;
  // scrambled address as read word, so a wrong address shows up in the data
  assign mem_rdata = dmem_addr ^ 16'hA5A5;
endmodule : dmem_model

// ===== verif/dsp_carry_acc_aux_datapath_tb_top.sv
`timescale 1ns/1ps
`include "dsp_datapath_cfg.svh"
module dsp_carry_acc_aux_datapath_tb_top;
  import dsp_datapath_pkg::*;
  typedef struct packed {op_code_t c; src_t s; word_t v; logic [7:0] r; acc_t acc; logic cy;} step_t;
  localparam step_t tbl [0:23] = '{
    '{OP_LOAD_ACC, SRC_PROD, 16'h0000, 8'h00, 32'hFFFF_FFFF, 1'b1},
    '{OP_ADD, SRC_IMM, 16'h0001, 8'h00, 32'h0000_0000, 1'b1},
    '{CLEAR_FLAG_OP, SRC_IMM, 16'h0000, 8'h00, 32'h0000_0000, 1'b0},
    '{OP_LOAD_ACC, SRC_PROD, 16'h0000, 8'h00, 32'hFFFF_FFFF, 1'b0},
    '{ADD_WITH_CARRY_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFFF, 1'b0},
    '{SET_FLAG_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFFF, 1'b1},
    '{ADD_WITH_CARRY_OP, SRC_IMM, 16'h0000, 8'h00, 32'h0000_0000, 1'b1},
    '{OP_SUB, SRC_IMM, 16'h0001, 8'h00, 32'hFFFF_FFFF, 1'b0},
    '{SUBTRACT_WITH_BORROW_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFFE, 1'b1},
    '{OP_SUB_HIGH, SRC_IMM, 16'h0001, 8'h00, 32'hFFFE_FFFE, 1'b1},
    '{OP_LOAD_ACC, SRC_IMM, 16'h0000, 8'h00, 32'h0000_0000, 1'b1},
    '{OP_SUB_HIGH, SRC_IMM, 16'h0001, 8'h00, 32'hFFFF_0000, 1'b0},
    '{OP_ADD_HIGH, SRC_IMM, 16'h0001, 8'h00, 32'h0000_0000, 1'b1},
    '{CLEAR_FLAG_OP, SRC_IMM, 16'h0000, 8'h00, 32'h0000_0000, 1'b0},
    '{OP_ADD_HIGH, SRC_IMM, 16'h0001, 8'h00, 32'h0001_0000, 1'b0},
    '{OP_LOAD_ACC, SRC_PROD, 16'h0000, 8'h00, 32'hFFFF_FFFF, 1'b0},
    '{OP_XOR, SRC_IMM, 16'h0002, 8'h00, 32'hFFFF_FFFD, 1'b0},
    '{ACC_SHIFT_RIGHT_OP, SRC_IMM, 16'h0000, 8'h00, 32'h7FFF_FFFE, 1'b1},
    '{ACC_ROTATE_LEFT_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFFD, 1'b0},
    '{ACC_ROTATE_RIGHT_OP, SRC_IMM, 16'h0000, 8'h00, 32'h7FFF_FFFE, 1'b1},
    '{ACC_SHIFT_LEFT_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFFC, 1'b0},
    '{ACC_SHIFT_LEFT_OP, SRC_IMM, 16'h0000, 8'h02, 32'hFFFF_FFE0, 1'b1},
    '{ACC_SHIFT_RIGHT_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFF0, 1'b0},
    '{ACC_SHIFT_LEFT_OP, SRC_IMM, 16'h0000, 8'h00, 32'hFFFF_FFE0, 1'b1}};
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic op_valid = 1'b0;
  op_t op = '0;
  cond_t cond_sel = COND_ALWAYS;
  acc_t prod = 32'hFFFF_FFFF;
  logic [11:0] awaddr = 12'h000;
  logic [11:0] araddr = 12'h000;
  logic [31:0] wdata = 32'h0000_0000;
  logic awvalid = 1'b0;
  logic wvalid = 1'b0;
  logic bready = 1'b0;
  logic arvalid = 1'b0;
  logic rready = 1'b0;
  logic op_ready, cond_true, store_valid, carry, awready, wready, bvalid, arready, rvalid;
  logic [1:0] bresp, rresp, resp;
  logic [31:0] rdata, rd;
  word_t mem_rdata, dmem_addr, store_data;
  acc_t accumulator_reg;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #12.5 aclk = ~aclk;
  dmem_model u_dmem (.dmem_addr(dmem_addr), .mem_rdata(mem_rdata));
  dsp_carry_acc_aux_datapath u_dut (.aclk(aclk), .aresetn(aresetn), .op_valid(op_valid), .op_ready(op_ready),
    .op(op), .mem_rdata(mem_rdata), .product_reg(prod), .cond_sel(cond_sel), .cond_true(cond_true),
    .dmem_addr(dmem_addr), .store_valid(store_valid), .store_data(store_data), .accumulator_reg(accumulator_reg),
    .carry(carry), .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF),
    .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));
  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : final_report
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic run(input op_code_t c, input src_t s = SRC_IMM, input word_t v = 16'h0000,
    input logic [7:0] r = 8'h00, input logic [2:0] sh = 3'h0, input addr_mode_t m = ADDR_NONE, input ptr_t a = 3'h0);
    @(posedge aclk);
    op <= '{code: c, src: s, operand: v, ar_sel: a, addr_mode: m, store_shift: sh, rpt_count: r};
    op_valid <= 1'b1;
    do @(posedge aclk); while (op_ready !== 1'b1);
    op_valid <= 1'b0;
    do @(negedge aclk); while (op_ready !== 1'b1);
  endtask : run
  task automatic axi_wr(input logic [11:0] a, input logic [31:0] d);
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready === 1'b1) awvalid <= 1'b0;
      if (wready === 1'b1) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    resp = bresp;
    bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [11:0] a);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready === 1'b1) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    resp = rresp;
    rd = rdata;
    rready <= 1'b0;
  endtask : axi_rd
  task automatic chk_cond(input logic cy);
    for (int k = 0; k < 4; k++) begin
      @(posedge aclk);
      cond_sel <= cond_t'(k);
      @(negedge aclk);
      chk(cond_true, (k == 0) ? cy : (k == 1) ? !cy : (k == 2));
    end
  endtask : chk_cond
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 5000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(negedge aclk);
    chk(carry, 1'b1);
    chk(accumulator_reg, 32'h0000_0000);
    axi_rd(`OFF_STATUS);
    chk(rd, 32'h0000_0001);
    chk_cond(1'b1);
    $display("test reset done");
    for (int k = 0; k < 8; k++) run(OP_LOAD_AR, SRC_IMM, 16'(16'h0F00 + 3 * k), 8'h00, 3'h0, ADDR_NONE, ptr_t'(k));
    for (int k = 0; k < 8; k++) begin
      run(OP_LOAD_PTR, SRC_IMM, 16'(k));
      chk(dmem_addr, 32'(16'h0F00 + 3 * k));
    end
    run(OP_LOAD_ACC, SRC_MEM);
    chk(accumulator_reg, 32'h0000_AAB0);
    run(OP_LOAD_PTR, SRC_IMM, 16'h0003);
    run(OP_NOP, SRC_IMM, 16'h0000, 8'h00, 3'h0, ADDR_INC);
    chk(dmem_addr, 32'h0000_0F0A);
    run(OP_NOP, SRC_IMM, 16'h0000, 8'h00, 3'h0, ADDR_DEC);
    chk(dmem_addr, 32'h0000_0F09);
    run(OP_NOP, SRC_IMM, 16'h0000, 8'h00, 3'h0, ADDR_ADD_INDEX);
    chk(dmem_addr, 32'h0000_1E09);
    run(OP_NOP, SRC_IMM, 16'h0000, 8'h00, 3'h0, ADDR_SUB_INDEX);
    chk(dmem_addr, 32'h0000_0F09);
    chk(accumulator_reg, 32'h0000_AAB0);
    run(OP_STORE_AR);
    chk(store_data, 32'h0000_0F09);
    $display("test aux done");
    for (int i = 0; i < 24; i++) begin
      if (i == 22) begin
        axi_wr(`OFF_CTRL, 32'h0000_0001);
        chk(resp, `RESP_OKAY);
      end
      run(tbl[i].c, tbl[i].s, tbl[i].v, tbl[i].r);
      chk(accumulator_reg, tbl[i].acc);
      chk(carry, tbl[i].cy);
    end
    $display("test arith done");
    run(OP_STORE_HI, SRC_IMM, 16'h0000, 8'h00, 3'h3);
    chk(store_valid, 1'b1);
    chk(store_data, 32'h0000_FFFF);
    run(OP_STORE_LO, SRC_IMM, 16'h0000, 8'h00, 3'h7);
    chk(store_data, 32'h0000_F000);
    chk(accumulator_reg, 32'hFFFF_FFE0);
    $display("test store done");
    run(CLEAR_FLAG_OP);
    chk(store_valid, 1'b0);
    chk_cond(1'b0);
    run(LOAD_STATUS_OP, SRC_IMM, 16'hA600);
    chk(carry, 1'b1);
    chk(dmem_addr, 32'h0000_0F0F);
    axi_rd(`OFF_STATUS);
    chk(rd, 32'h0000_0053);
    axi_wr(12'h020, 32'h0000_0000);
    chk(resp, `RESP_SLVERR);
    axi_rd(12'h020);
    chk(rd, 32'h0000_0000);
    chk(resp, `RESP_SLVERR);
    $display("test status done");
    // high-half ops that must leave carry alone: add with carry set, subtract with carry clear
    run(OP_LOAD_ACC, SRC_IMM, 16'h0000);
    run(OP_ADD_HIGH, SRC_IMM, 16'h0001);
    chk(accumulator_reg, 32'h0001_0000);
    chk(carry, 1'b1);
    run(CLEAR_FLAG_OP);
    run(OP_SUB_HIGH, SRC_IMM, 16'h0001);
    chk(accumulator_reg, 32'h0000_0000);
    chk(carry, 1'b0);
    run(OP_OR, SRC_IMM, 16'h1F10);
    chk(accumulator_reg, 32'h0000_1F10);
    run(OP_AND, SRC_AUX);
    chk(accumulator_reg, 32'h0000_0F00);
    chk(carry, 1'b0);
    run(OP_LOAD_AR, SRC_ACC, 16'h0000, 8'h00, 3'h0, ADDR_NONE, 3'h5);
    chk(dmem_addr, 32'h0000_0F00);
    @(posedge aclk);
    prod <= 32'h1234_5672;
    run(OP_LOAD_PTR, SRC_PROD);
    chk(dmem_addr, 32'h0000_0F06);
    $display("test sources done");
    final_report();
  end
endmodule : dsp_carry_acc_aux_datapath_tb_top
